/* File: rtl/alb_defines.vh */
// alb_defines.vh: constants of the at-speed link self-test block
// assumes: included by bare name from the rtl files of this block
`ifndef ALB_DEFINES_VH
`define ALB_DEFINES_VH

// ------------------------------------------------------------
// link framing and pattern
// ------------------------------------------------------------
`define ALB_FRAME_BITS 21
`define ALB_PRBS_BITS 7
`define ALB_POP_BITS 5
`define ALB_FIFO_DEPTH 8
`define ALB_FIFO_ABITS 3

// ------------------------------------------------------------
// timing: half a link clock period, link clock 160 ns, clock 5 ns
// ------------------------------------------------------------
`define ALB_CLOCK_PERIOD_PS 5000
`define ALB_HALF_PIXEL_PS 80000
`define ALB_HALF_PIXEL_CYCLES (`ALB_HALF_PIXEL_PS / `ALB_CLOCK_PERIOD_PS)
`define ALB_HALF_CNT_BITS 8
`define ALB_PEND_BITS 8
`define ALB_PEND_LIMIT 8'hc0

// ------------------------------------------------------------
// test sequencer states
// ------------------------------------------------------------
`define ALB_ST_IDLE 2'h0
`define ALB_ST_TEST 2'h1
`define ALB_ST_DONE 2'h2

// ------------------------------------------------------------
// register map (byte addresses) and fields
// ------------------------------------------------------------
`define ALB_ADDR_BITS 8
`define ALB_OFS_CONTROL 8'h00
`define ALB_OFS_STATUS 8'h04
`define ALB_OFS_ERRCOUNT 8'h08
`define ALB_CTRL_PULSE_EN 0
`define ALB_CTRL_RESET 1'h1
`define ALB_STAT_ACTIVE 0
`define ALB_STAT_PASS 1
`define ALB_STAT_LOCKED 2
`define ALB_STAT_ANYERR 3
`define ALB_STAT_DONE 4
`define ALB_STAT_OVERRUN 5
`define ALB_HTRANS_NONSEQ 2'h2
`define ALB_HTRANS_SEQ 2'h3

`endif

/* File: rtl/alb_fifo.v */
// alb_fifo.v: small synchronous fifo with valid/ready on both sides
// assumes: one clock, synchronous active-high reset
`timescale 1ns/1ps
`include "alb_defines.vh"

module alb_fifo #(
   parameter WIDTH = `ALB_FRAME_BITS,
   parameter DEPTH = `ALB_FIFO_DEPTH,
   parameter ABITS = `ALB_FIFO_ABITS
)
(
   // clock and reset
   input wire clock,
   input wire reset,
   // fill side
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   // drain side
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [ABITS-1:0] wrPtr_reg;
   reg [ABITS-1:0] rdPtr_reg;
   reg [ABITS:0] count_reg;
   wire push;
   wire pop;

   assign inReady = (count_reg != DEPTH[ABITS:0]);
   assign outValid = (count_reg != {(ABITS+1){1'b0}});
   assign outData = mem[rdPtr_reg];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   always @(posedge clock)
   begin
      if (push)
      begin
         mem[wrPtr_reg] <= inData;
      end
      if (reset)
      begin
         wrPtr_reg <= {ABITS{1'b0}};
         rdPtr_reg <= {ABITS{1'b0}};
         count_reg <= {(ABITS+1){1'b0}};
      end
      else
      begin
         if (push)
            wrPtr_reg <= wrPtr_reg + 1'b1;
         if (pop)
            rdPtr_reg <= rdPtr_reg + 1'b1;
         if (push & ~pop)
            count_reg <= count_reg + 1'b1;
         else if (pop & ~push)
            count_reg <= count_reg - 1'b1;
      end
   end

endmodule // alb_fifo

/* File: rtl/alb_pin_sync.v */
// alb_pin_sync.v: three-stage synchroniser with agreement filter
// assumes: input is asynchronous to clock
`timescale 1ns/1ps

module alb_pin_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
)
(
   // clock and reset
   input wire clock,
   input wire reset,
   // pins
   input wire [WIDTH-1:0] pinIn,
   output reg [WIDTH-1:0] level
);

   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;
   reg [WIDTH-1:0] stage3_reg;

   // stage1 feeds stage2 only; a change counts once stage2 and stage3 agree
   always @(posedge clock)
   begin
      if (reset)
      begin
         stage1_reg <= INIT;
         stage2_reg <= INIT;
         stage3_reg <= INIT;
         level <= INIT;
      end
      else
      begin
         stage1_reg <= pinIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         level <= (stage2_reg == stage3_reg) ? stage3_reg : level;
      end
   end

endmodule // alb_pin_sync

/* File: rtl/alb_self_test.v */
// alb_self_test.v: deserializer-side at-speed link self-test
// assumes: link clock and data, lock and control pins arrive unsynchronised;
// registers reached over AHB-Lite, single word transfers, one slave
`timescale 1ns/1ps
`include "alb_defines.vh"

module alb_self_test
(
   // clock and reset
   input wire clock,
   input wire reset,
   // control pins
   input wire selfTestEnable,
   input wire [1:0] oscSelectInputs,
   input wire powerDownN,
   input wire modeCamera,
   input wire linkLocked,
   // high-speed link, sampled
   input wire linkClock,
   input wire linkData,
   // back channel towards the serializer
   output reg backTestMode,
   output reg [1:0] backOscSelect,
   output reg backUseExtClock,
   output reg linkErrorFlagOut,
   // result pin
   output reg passOut,
   // ahb-lite slave
   input wire hsel,
   input wire [`ALB_ADDR_BITS-1:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hwdata,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp
);

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // next frame of the serial prbs7 sequence, newest bit in lsb
   function [`ALB_FRAME_BITS+`ALB_PRBS_BITS-1:0] prbsFrame;
      input [`ALB_PRBS_BITS-1:0] seed;
      reg [`ALB_PRBS_BITS-1:0] s;
      reg [`ALB_FRAME_BITS-1:0] w;
      reg nb;
      integer i;
      begin
         s = seed;
         w = {`ALB_FRAME_BITS{1'b0}};
         nb = 1'b0;
         for (i = 0; i < `ALB_FRAME_BITS; i = i + 1)
         begin
            nb = s[6] ^ s[5];
            s = {s[5:0], nb};
            w = {w[`ALB_FRAME_BITS-2:0], nb};
         end
         prbsFrame = {s, w};
      end
   endfunction

   function [`ALB_POP_BITS-1:0] bitCount;
      input [`ALB_FRAME_BITS-1:0] v;
      integer i;
      begin
         bitCount = {`ALB_POP_BITS{1'b0}};
         for (i = 0; i < `ALB_FRAME_BITS; i = i + 1)
            bitCount = bitCount + {{(`ALB_POP_BITS-1){1'b0}}, v[i]};
      end
   endfunction

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   wire enSync;
   wire pdnSync;
   wire camSync;
   wire lockSync;
   wire lclkSync;
   wire ldatSync;
   wire [1:0] oscSync;
   wire oscDummy;

   // power-down stage starts high so reset does not fake a power-down release
   alb_pin_sync #(.WIDTH(7), .INIT(7'h20)) pinSync (
      .clock(clock),
      .reset(reset),
      .pinIn({selfTestEnable, powerDownN, modeCamera, linkLocked, linkClock, linkData,
              1'b0}),
      .level({enSync, pdnSync, camSync, lockSync, lclkSync, ldatSync, oscDummy})
   );

   alb_pin_sync #(.WIDTH(2), .INIT(2'h0)) oscPinSync (
      .clock(clock),
      .reset(reset),
      .pinIn(oscSelectInputs),
      .level(oscSync)
   );

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg pdnPrev_reg;
   wire pdnClear;
   wire testOn;

   // power-down held low, or its release, wipes the result
   assign pdnClear = ~pdnSync | (pdnSync & ~pdnPrev_reg);
   assign testOn = (state_reg == `ALB_ST_TEST);

   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         `ALB_ST_IDLE, `ALB_ST_DONE:
            if (enSync & lockSync & camSync)
               state_next = `ALB_ST_TEST;
         `ALB_ST_TEST:
            if (~enSync)
               state_next = `ALB_ST_DONE;
         default:
            state_next = `ALB_ST_IDLE;
      endcase
      if (pdnClear)
         state_next = `ALB_ST_IDLE;
   end

   always @(posedge clock)
   begin
      if (reset)
      begin
         state_reg <= `ALB_ST_IDLE;
         pdnPrev_reg <= 1'b1;
         backTestMode <= 1'b0;
         backOscSelect <= 2'h0;
         backUseExtClock <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         pdnPrev_reg <= pdnSync;
         backTestMode <= (state_next == `ALB_ST_TEST);
         if (state_reg != `ALB_ST_TEST)
         begin
            backOscSelect <= oscSync;
            backUseExtClock <= (oscSync == 2'h0);
         end
      end
   end

   // ------------------------------------------------------------
   // link deframer: link clock found by its rising edge
   // ------------------------------------------------------------
   reg lclkPrev_reg;
   reg [`ALB_FRAME_BITS-1:0] shift_reg;
   reg [`ALB_POP_BITS-1:0] bitIdx_reg;
   reg frameValid_reg;
   reg overrun_reg;
   wire lclkRise;
   wire fifoInReady;
   wire fifoOutValid;
   wire fifoOutReady;
   wire [`ALB_FRAME_BITS-1:0] fifoOutData;

   assign lclkRise = lclkSync & ~lclkPrev_reg;

   always @(posedge clock)
   begin
      if (reset | ~testOn)
      begin
         lclkPrev_reg <= lclkSync;
         shift_reg <= {`ALB_FRAME_BITS{1'b0}};
         bitIdx_reg <= {`ALB_POP_BITS{1'b0}};
         frameValid_reg <= 1'b0;
      end
      else
      begin
         lclkPrev_reg <= lclkSync;
         frameValid_reg <= 1'b0;
         if (lclkRise)
         begin
            shift_reg <= {shift_reg[`ALB_FRAME_BITS-2:0], ldatSync};
            if (bitIdx_reg == `ALB_FRAME_BITS - 1)
            begin
               bitIdx_reg <= {`ALB_POP_BITS{1'b0}};
               frameValid_reg <= 1'b1;
            end
            else
               bitIdx_reg <= bitIdx_reg + 1'b1;
         end
      end
   end

   // the link cannot be stalled; a frame that finds the fifo full counts as lost
   always @(posedge clock)
   begin
      if (reset | pdnClear | (state_next == `ALB_ST_TEST & ~testOn))
         overrun_reg <= 1'b0;
      else if (frameValid_reg & ~fifoInReady)
         overrun_reg <= 1'b1;
   end

   alb_fifo #(.WIDTH(`ALB_FRAME_BITS), .DEPTH(`ALB_FIFO_DEPTH), .ABITS(`ALB_FIFO_ABITS))
   frameFifo (
      .clock(clock),
      .reset(reset | ~testOn),
      .inValid(frameValid_reg),
      .inReady(fifoInReady),
      .inData({shift_reg[`ALB_FRAME_BITS-2:0], ldatSync} & {`ALB_FRAME_BITS{1'b0}}
              | shift_reg),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   // ------------------------------------------------------------
   // checker
   // ------------------------------------------------------------
   reg synced_reg;
   reg [`ALB_PRBS_BITS-1:0] seed_reg;
   reg anyError_reg;
   reg [31:0] errCount_reg;
   reg [`ALB_PEND_BITS-1:0] pending_reg;
   reg [`ALB_HALF_CNT_BITS-1:0] halfCnt_reg;
   reg pulseLow_reg;
   reg pulseBusy_reg;
   reg ctrlPulseEn_reg;
   wire [`ALB_FRAME_BITS+`ALB_PRBS_BITS-1:0] prbsNext;
   wire [`ALB_POP_BITS-1:0] badBits;
   wire checkNow;
   wire pulseDone;
   wire newSession;

   assign prbsNext = prbsFrame(seed_reg);
   // error pulses queue up; when the queue is near full the fifo is stalled
   assign fifoOutReady = (pending_reg < `ALB_PEND_LIMIT);
   assign checkNow = fifoOutValid & fifoOutReady & testOn;
   assign badBits = (synced_reg & checkNow) ?
                    bitCount(fifoOutData ^ prbsNext[`ALB_FRAME_BITS-1:0]) :
                    {`ALB_POP_BITS{1'b0}};
   assign pulseDone = pulseBusy_reg & ~pulseLow_reg &
                      (halfCnt_reg == `ALB_HALF_PIXEL_CYCLES - 1);
   assign newSession = (state_next == `ALB_ST_TEST) & ~testOn;

   always @(posedge clock)
   begin
      if (reset | pdnClear | newSession)
      begin
         synced_reg <= 1'b0;
         seed_reg <= {`ALB_PRBS_BITS{1'b0}};
         anyError_reg <= 1'b0;
         errCount_reg <= 32'h0;
         pending_reg <= {`ALB_PEND_BITS{1'b0}};
      end
      else
      begin
         if (checkNow)
         begin
            synced_reg <= 1'b1;
            // first frame seeds, later frames follow the local sequence
            seed_reg <= synced_reg ? prbsNext[`ALB_FRAME_BITS+`ALB_PRBS_BITS-1:`ALB_FRAME_BITS]
                                   : fifoOutData[`ALB_PRBS_BITS-1:0];
         end
         if (badBits != {`ALB_POP_BITS{1'b0}} || (overrun_reg & testOn & ~anyError_reg))
            anyError_reg <= 1'b1;
         if (errCount_reg <= 32'hffffffe0)
            errCount_reg <= errCount_reg + {27'h0, badBits};
         pending_reg <= pending_reg + {{(`ALB_PEND_BITS-`ALB_POP_BITS){1'b0}}, badBits}
                        - {{(`ALB_PEND_BITS-1){1'b0}}, pulseDone};
      end
   end

   // ------------------------------------------------------------
   // pass pin pulse generator: low half period, high half period
   // ------------------------------------------------------------
   always @(posedge clock)
   begin
      if (reset | pdnClear | newSession)
      begin
         halfCnt_reg <= {`ALB_HALF_CNT_BITS{1'b0}};
         pulseLow_reg <= 1'b0;
         pulseBusy_reg <= 1'b0;
      end
      else if (~pulseBusy_reg)
      begin
         if (pending_reg != {`ALB_PEND_BITS{1'b0}} & ctrlPulseEn_reg)
         begin
            pulseBusy_reg <= 1'b1;
            pulseLow_reg <= 1'b1;
            halfCnt_reg <= {`ALB_HALF_CNT_BITS{1'b0}};
         end
      end
      else if (halfCnt_reg == `ALB_HALF_PIXEL_CYCLES - 1)
      begin
         halfCnt_reg <= {`ALB_HALF_CNT_BITS{1'b0}};
         pulseLow_reg <= 1'b0;
         if (~pulseLow_reg)
            pulseBusy_reg <= 1'b0;
      end
      else
         halfCnt_reg <= halfCnt_reg + 1'b1;
   end

   // ------------------------------------------------------------
   // result outputs
   // ------------------------------------------------------------
   always @(posedge clock)
   begin
      if (reset)
      begin
         passOut <= 1'b1;
         linkErrorFlagOut <= 1'b0;
      end
      else if (pdnClear)
      begin
         passOut <= 1'b1;
         linkErrorFlagOut <= 1'b0;
      end
      else
      begin
         if (testOn)
            passOut <= ctrlPulseEn_reg ? ~pulseLow_reg : ~anyError_reg;
         else if (state_reg == `ALB_ST_DONE)
            passOut <= ~anyError_reg;
         linkErrorFlagOut <= testOn & (anyError_reg | overrun_reg);
      end
   end

   // ------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ------------------------------------------------------------
   reg wrPend_reg;
   reg [`ALB_ADDR_BITS-1:0] wrAddr_reg;
   wire addrPhase;
   wire [31:0] statusWord;

   assign addrPhase = hsel & hready & (htrans == `ALB_HTRANS_NONSEQ | htrans == `ALB_HTRANS_SEQ);
   assign statusWord = {26'h0, overrun_reg, (state_reg == `ALB_ST_DONE), anyError_reg,
                        lockSync, passOut, testOn};

   always @(posedge clock)
   begin
      if (reset)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0;
         wrPend_reg <= 1'b0;
         wrAddr_reg <= {`ALB_ADDR_BITS{1'b0}};
         ctrlPulseEn_reg <= `ALB_CTRL_RESET;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (wrPend_reg & wrAddr_reg == `ALB_OFS_CONTROL)
            ctrlPulseEn_reg <= hwdata[`ALB_CTRL_PULSE_EN];
         wrPend_reg <= addrPhase & hwrite;
         wrAddr_reg <= haddr;
         hrdata <= 32'h0;
         if (addrPhase & ~hwrite)
         begin
            case (haddr)
               `ALB_OFS_CONTROL: hrdata <= {31'h0, ctrlPulseEn_reg};
               `ALB_OFS_STATUS: hrdata <= statusWord;
               `ALB_OFS_ERRCOUNT: hrdata <= errCount_reg;
               default: hrdata <= 32'h0;
            endcase
         end
      end
   end

endmodule // alb_self_test

/* File: tb/alb_link_model.sv */
// alb_link_model.sv: serializer stand-in sending pattern frames on the link
// assumes: run is high while the block commands test mode; 160 ns link clock
`timescale 1ns/1ps

module alb_link_model
(
   // control from the bench
   input wire logic run,
   input wire logic [20:0] errMask,
   // serial link
   output logic linkClock,
   output logic linkData,
   output logic [15:0] frameCount
);
   logic [6:0] prbs;
   logic [20:0] mask;
   logic nextBit;
   initial
   begin
      linkClock = 1'b0;
      linkData = 1'b0;
      frameCount = 16'h0;
      prbs = 7'h7f;
      // offset keeps the link phase unrelated to the block clock
      #1.3;
      forever
      begin
         if (run !== 1'b1)
         begin
            // link clock stands still, data line keeps moving
            #80 linkData = ~linkData;
         end
         else
         begin
            // frames only while run is high, msb first
            mask = errMask;
            for (int i = 20; i >= 0; i--)
            begin
               nextBit = prbs[6] ^ prbs[5];
               prbs = {prbs[5:0], nextBit};
               linkData = nextBit ^ mask[i];
               #80 linkClock = 1'b1;
               #80 linkClock = 1'b0;
            end
            frameCount = frameCount + 16'h1;
         end
      end
   end
endmodule // alb_link_model

/* File: tb/alb_self_test_monitor.sv */
// alb_self_test_monitor.sv: port assertions for the self-test block
// assumes: bound into alb_self_test, one clock domain
`timescale 1ns/1ps

module alb_self_test_monitor
(
   // clock and reset
   input wire clock,
   input wire reset,
   // pins
   input wire selfTestEnable,
   input wire modeCamera,
   input wire linkLocked,
   input wire backTestMode,
   input wire [1:0] backOscSelect,
   input wire backUseExtClock,
   input wire linkErrorFlagOut,
   input wire passOut
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_reset_values: assert property (disable iff (1'b0) reset |=> passOut && !backTestMode)
      else $error("pass or test mode wrong after reset");
   a_start_needs: assert property ($rose(backTestMode) |-> $past(selfTestEnable, 2)
      && $past(linkLocked, 2)) else $error("test started without enable and lock");
   a_camera_only: assert property ($rose(backTestMode) |-> $past(modeCamera, 2))
      else $error("test started outside camera mode");
   a_end_follows: assert property ($fell(selfTestEnable) |-> ##[1:12] !backTestMode)
      else $error("test did not end after enable fell");
   a_select_frozen: assert property (backTestMode && $past(backTestMode) |->
      $stable(backOscSelect)) else $error("oscillator select moved during test");
   a_ext_bypass: assert property (backTestMode && $past(backTestMode) |->
      backUseExtClock == (backOscSelect == 2'h0)) else $error("bypass flag disagrees");
   a_fail_low: assert property ($fell(passOut) |-> !passOut [*8] ##1 !passOut [*8])
      else $error("fail pulse shorter than half a link clock");
   a_toggle_high: assert property ($rose(passOut) && backTestMode |->
      passOut [*8] ##1 passOut [*8]) else $error("toggle high phase too short");
   a_flag_on_fail: assert property ($fell(passOut) && backTestMode |->
      ##[0:4] linkErrorFlagOut) else $error("error flag missing on failure");
   c_test_start: cover property ($rose(backTestMode));
   c_pass_fall: cover property ($fell(passOut));
   c_flag_rise: cover property ($rose(linkErrorFlagOut));
endmodule // alb_self_test_monitor

bind alb_self_test alb_self_test_monitor mon (.clock(clock), .reset(reset),
   .selfTestEnable(selfTestEnable), .modeCamera(modeCamera), .linkLocked(linkLocked),
   .backTestMode(backTestMode), .backOscSelect(backOscSelect),
   .backUseExtClock(backUseExtClock), .linkErrorFlagOut(linkErrorFlagOut), .passOut(passOut));

/* File: tb/at_speed_link_bist_bench.sv */
// at_speed_link_bist_bench.sv: self-checking bench of the link self-test block
// assumes: alb_self_test, alb_link_model, 5 ns clock, ahb-lite single slave
`timescale 1ns/1ps
`include "alb_defines.vh"

module at_speed_link_bist_bench;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic selfTestEnable = 1'b0;
   logic [1:0] oscSelectInputs = 2'h1;
   logic powerDownN = 1'b1;
   logic modeCamera = 1'b1;
   logic linkLocked = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic keepRun = 1'b0;
   logic [20:0] errMask = 21'h0;
   logic passPrev = 1'b1;
   logic [31:0] rd;
   int riseCount = 0;
   int base;
   int errors = 0;
   int checked = 0;
   wire linkClock, linkData, backTestMode, backUseExtClock, linkErrorFlagOut, passOut;
   wire hreadyout, hresp;
   wire [1:0] backOscSelect;
   wire [31:0] hrdata;
   wire [15:0] frameCount;
   always #2.5 clock = ~clock;
   alb_self_test uut (.clock(clock), .reset(reset), .selfTestEnable(selfTestEnable),
      .oscSelectInputs(oscSelectInputs), .powerDownN(powerDownN), .modeCamera(modeCamera),
      .linkLocked(linkLocked), .linkClock(linkClock), .linkData(linkData),
      .backTestMode(backTestMode), .backOscSelect(backOscSelect),
      .backUseExtClock(backUseExtClock), .linkErrorFlagOut(linkErrorFlagOut),
      .passOut(passOut), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp));
   alb_link_model link (.run(backTestMode | keepRun), .errMask(errMask),
      .linkClock(linkClock), .linkData(linkData), .frameCount(frameCount));
   // counts pass pin rises, one per bit error while toggling
   always @(posedge clock)
   begin
      passPrev <= passOut;
      if (passOut === 1'b1 && passPrev === 1'b0)
         riseCount <= riseCount + 1;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= `ALB_HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
      check("hresp", 32'h0, hresp);
   endtask
   task automatic waitFor(input logic lvl);
      int n;
      n = 0;
      while (backTestMode !== lvl && n < 400)
      begin
         @(posedge clock);
         n++;
      end
      check("backTestMode", lvl, backTestMode);
   endtask
   task automatic waitFrames(input int n);
      int start;
      int k;
      start = frameCount;
      k = 0;
      while (int'(frameCount) < start + n && k < n * 800)
      begin
         @(posedge clock);
         k++;
      end
   endtask
   task automatic startTest(input logic [1:0] osc);
      @(posedge clock);
      oscSelectInputs <= osc;
      selfTestEnable <= 1'b1;
      // lock arrives well after enable, short of the real wait
      cyc(20);
      linkLocked <= 1'b1;
      waitFor(1'b1);
   endtask
   task automatic stopTest;
      @(posedge clock);
      selfTestEnable <= 1'b0;
      waitFor(1'b0);
      linkLocked <= 1'b0;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic testResetRegs;
      check("passOut", 32'h1, passOut);
      ahb(1'b0, `ALB_OFS_CONTROL, 32'h0);
      check("control", 32'h1, rd);
      ahb(1'b1, `ALB_OFS_CONTROL, 32'h0);
      ahb(1'b0, `ALB_OFS_CONTROL, 32'h0);
      check("control", 32'h0, rd);
      ahb(1'b1, `ALB_OFS_CONTROL, 32'h1);
      ahb(1'b0, `ALB_OFS_CONTROL, 32'h0);
      check("control", 32'h1, rd);
      ahb(1'b0, `ALB_OFS_STATUS, 32'h0);
      check("status", 32'h2, rd);
      ahb(1'b1, 8'h0c, 32'hffffffff);
      ahb(1'b0, 8'h0c, 32'h0);
      check("unmapped", 32'h0, rd);
      $display("test reset_regs done");
   endtask
   task automatic testOscCodes;
      for (int k = 0; k < 4; k++)
      begin
         startTest(k[1:0]);
         check("backOscSelect", k, backOscSelect);
         check("backUseExtClock", k == 0, backUseExtClock);
         stopTest();
      end
      $display("test osc_codes done");
   endtask
   task automatic testClean;
      startTest(2'h1);
      base = riseCount;
      waitFrames(4);
      check("passOut", 32'h1, passOut);
      keepRun <= 1'b1;
      stopTest();
      errMask <= 21'h000100;
      waitFrames(2);
      errMask <= 21'h0;
      cyc(100);
      check("passOut", 32'h1, passOut);
      check("rises", 0, riseCount - base);
      ahb(1'b0, `ALB_OFS_STATUS, 32'h0);
      check("status", 32'h12, rd);
      ahb(1'b0, `ALB_OFS_ERRCOUNT, 32'h0);
      check("errcount", 32'h0, rd);
      keepRun <= 1'b0;
      $display("test clean done");
   endtask
   task automatic testErrors;
      startTest(2'h0);
      base = riseCount;
      waitFrames(2);
      errMask <= 21'h000404;
      waitFrames(1);
      errMask <= 21'h0;
      waitFrames(1);
      cyc(200);
      check("rises", 2, riseCount - base);
      check("linkErrorFlagOut", 32'h1, linkErrorFlagOut);
      ahb(1'b0, `ALB_OFS_ERRCOUNT, 32'h0);
      check("errcount", 32'h2, rd);
      stopTest();
      cyc(200);
      check("passOut", 32'h0, passOut);
      powerDownN <= 1'b0;
      cyc(10);
      powerDownN <= 1'b1;
      cyc(20);
      check("passOut", 32'h1, passOut);
      $display("test errors done");
   endtask
   task automatic testRefused;
      modeCamera <= 1'b0;
      selfTestEnable <= 1'b1;
      linkLocked <= 1'b1;
      cyc(100);
      check("backTestMode", 32'h0, backTestMode);
      modeCamera <= 1'b1;
      linkLocked <= 1'b0;
      cyc(100);
      check("backTestMode", 32'h0, backTestMode);
      linkLocked <= 1'b1;
      waitFor(1'b1);
      ahb(1'b0, `ALB_OFS_ERRCOUNT, 32'h0);
      check("errcount", 32'h0, rd);
      stopTest();
      $display("test refused done");
   endtask
   task automatic tally_and_finish;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      cyc(12);
      reset <= 1'b0;
      cyc(6);
      testResetRegs();
      testOscCodes();
      testClean();
      testErrors();
      testRefused();
      tally_and_finish();
   end
   initial
   begin
      #400000;
      errors++;
      $display("ERROR watchdog expected done seen timeout");
      tally_and_finish();
   end
endmodule // at_speed_link_bist_bench
